// file: src/cstt_pkg.sv
// Constants and types for the counter sample trigger timing block
// Behaviour
// - Frame mode: each completed process-data exchange starts a counter sample.
// - Frame mode: that sample is offered to the next retrieving frame.
// - Clock mode: the local clock unit starts samples at a constant period.
// - Clock mode: sample instants align to the time base within 100 ns.
// - Clock mode: the sync0 pulse starts each cyclic counter acquisition.
// - Shift is loadable only at startup, then frozen until reset.
// - Input-aligned mode places sync before the frame using the input shift.
// - Plain clock mode fires sync shortly after the frame has passed.
// - Position becomes available about 80 us after each sync event.
// - Provision duration is measured on request and reported in a register.
// - Positive shift delays query; late finish means no fresh value that cycle.
// - Negative shift queries earlier, giving older values and more margin.
// - Sampling period is a whole multiple of the bus cycle time.
// - User-defined period in ns up to 32 bits is accepted.
// - Sync shift is set in ns steps relative to the global sync.
// - With input reference set, the input shift adds to the sync shift.
// - Sync0 generation is enabled whenever a clock-synchronous mode runs.
// - Sync1 configuration has no effect on counter sampling.
package cstt_pkg;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CYCLE = 8'h04;
	localparam logic [7:0] ADDR_MULT = 8'h08;
	localparam logic [7:0] ADDR_SHIFT = 8'h0C;
	localparam logic [7:0] ADDR_INSHIFT = 8'h10;
	localparam logic [7:0] ADDR_MEAS = 8'h14;
	localparam logic [7:0] ADDR_HELD = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1C;
	localparam int CLK_NS = 25;
	localparam logic [31:0] NS_STEP = 32'h0000_0019;
	localparam int PROV_US = 80;
	localparam int PROV_CYC = (PROV_US * 1000) / CLK_NS;
	localparam logic [11:0] PROV_LAST = 12'(PROV_CYC - 1);
	localparam logic [31:0] CYCLE_RST = 32'h003D_0900;
	localparam logic [31:0] MULT_RST = 32'h0000_0001;
	localparam int CTRL_MODE_LO = 0;
	localparam int CTRL_RUN = 2;
	localparam int CTRL_INREF = 3;
	localparam int CTRL_SYNC1 = 4;
	localparam int CTRL_MEAS = 5;
	typedef enum logic [1:0] {
		MODE_FRAME,
		MODE_DC,
		MODE_INPUT
	} cstt_mode_t;
	typedef enum logic {
		PH_IDLE,
		PH_PROV
	} cstt_phase_t;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} cstt_apb_req_t;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} cstt_apb_rsp_t;
endpackage

// file: src/cstt_trigger.sv
// Counter sample trigger timing with APB register access
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cstt_trigger import cstt_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire cstt_apb_req_t apb_req,
	output cstt_apb_rsp_t apb_rsp,
	// Fieldbus frame events
	input wire logic frame_done,
	input wire logic frame_fetch,
	// Encoder counter
	input wire logic [31:0] enc_count,
	// Process data and sync
	output logic [31:0] pd_value,
	output logic pd_fresh,
	output logic sync0,
	output logic sync0_en
);
	typedef struct packed {
		cstt_mode_t mode;
		logic run;
		logic inref;
		logic sync1_cfg;
		logic meas_en;
		logic [31:0] cycle;
		logic [31:0] mult;
		logic [31:0] shift;
		logic [31:0] inshift;
		logic [31:0] now;
		logic [31:0] next_evt;
		cstt_phase_t phase;
		logic [11:0] pcnt;
		logic [31:0] snap;
		logic [31:0] meas;
		logic ready;
		logic [31:0] ready_val;
		logic [31:0] pd;
		logic fresh;
		logic missed;
		logic sync0;
		logic sync0_en;
		cstt_apb_rsp_t rsp;
	} cstt_state_t;

	cstt_state_t st_r;
	cstt_state_t st_nxt;
	logic setup;
	logic wr;
	logic [31:0] period;
	logic [31:0] shift_tot;
	logic dc_hit;
	logic trig;
	logic [31:0] rdata;

	assign setup = apb_req.psel && !apb_req.penable;
	assign wr = apb_req.psel && apb_req.penable && st_r.rsp.pready && apb_req.pwrite;

	// Zero multiplier selects the user-defined period in ns
	assign period = (st_r.mult == 32'h0) ? st_r.cycle
		: 32'(st_r.mult * st_r.cycle);

	// Input shift joins only where inputs must lead the frame
	assign shift_tot = (st_r.mode == MODE_INPUT || (st_r.mode == MODE_DC && st_r.inref))
		? 32'(st_r.shift + st_r.inshift) : st_r.shift;

	// Signed distance survives wrap of the 32-bit ns time base
	assign dc_hit = st_r.run && st_r.mode != MODE_FRAME
		&& $signed(st_r.now - st_r.next_evt) >= 0;

	assign trig = (st_r.run && st_r.mode == MODE_FRAME && frame_done)
		|| dc_hit;

	always_comb begin
		unique case (apb_req.paddr)
			ADDR_CTRL: begin
				rdata = {26'h0, st_r.meas_en, st_r.sync1_cfg, st_r.inref, st_r.run,
					st_r.mode};
			end
			ADDR_CYCLE: begin
				rdata = st_r.cycle;
			end
			ADDR_MULT: begin
				rdata = st_r.mult;
			end
			ADDR_SHIFT: begin
				rdata = st_r.shift;
			end
			ADDR_INSHIFT: begin
				rdata = st_r.inshift;
			end
			ADDR_MEAS: begin
				rdata = st_r.meas;
			end
			ADDR_HELD: begin
				rdata = st_r.pd;
			end
			ADDR_STATUS: begin
				rdata = {28'h0, st_r.missed, st_r.fresh, st_r.ready,
					st_r.phase == PH_PROV};
			end
			default: begin
				rdata = 32'h0;
			end
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.now = 32'(st_r.now + NS_STEP);
		st_nxt.sync0 = 1'b0;
		st_nxt.rsp.pready = setup;
		st_nxt.rsp.pslverr = 1'b0;
		if (setup) begin
			st_nxt.rsp.pslverr = apb_req.paddr[1:0] != 2'b00 || apb_req.paddr > ADDR_STATUS;
		end
		// Read data launched with pready so it stands in the access cycle
		st_nxt.rsp.prdata = 32'h0;
		if (setup && !apb_req.pwrite) begin
			st_nxt.rsp.prdata = rdata;
		end
		// Configuration only while stopped: frozen once running, except meas_en below
		if (wr && !st_r.run) begin
			unique case (apb_req.paddr)
				ADDR_CTRL: begin
					st_nxt.mode = (apb_req.pwdata[1:0] > 2'h2) ? MODE_FRAME
						: cstt_mode_t'(apb_req.pwdata[CTRL_MODE_LO +: 2]);
					st_nxt.inref = apb_req.pwdata[CTRL_INREF];
					st_nxt.sync1_cfg = apb_req.pwdata[CTRL_SYNC1];
					st_nxt.meas_en = apb_req.pwdata[CTRL_MEAS];
					st_nxt.run = apb_req.pwdata[CTRL_RUN];
				end
				ADDR_CYCLE: begin
					st_nxt.cycle = apb_req.pwdata;
				end
				ADDR_MULT: begin
					st_nxt.mult = apb_req.pwdata;
				end
				ADDR_SHIFT: begin
					st_nxt.shift = apb_req.pwdata;
				end
				ADDR_INSHIFT: begin
					st_nxt.inshift = apb_req.pwdata;
				end
				default: begin
				end
			endcase
			// First event one period after start, moved by the shift
			if (apb_req.paddr == ADDR_CTRL && apb_req.pwdata[CTRL_RUN]) begin
				st_nxt.next_evt = 32'(st_r.now + period + shift_tot);
				st_nxt.sync0_en = apb_req.pwdata[1:0] == 2'h1
					|| apb_req.pwdata[1:0] == 2'h2;
			end
		end
		// Measurement enable may toggle while running
		if (wr && st_r.run && apb_req.paddr == ADDR_CTRL) begin
			st_nxt.meas_en = apb_req.pwdata[CTRL_MEAS];
		end
		if (dc_hit) begin
			st_nxt.next_evt = 32'(st_r.next_evt + period);
			st_nxt.sync0 = 1'b1;
		end
		// Retrieving frame takes what is ready; late provision is missed
		// Fetch handled first so a sample completing in the same cycle survives
		if (frame_fetch && st_r.run) begin
			if (st_r.ready) begin
				st_nxt.pd = st_r.ready_val;
				st_nxt.fresh = 1'b1;
				st_nxt.ready = 1'b0;
			end else begin
				st_nxt.fresh = 1'b0;
				st_nxt.missed = 1'b1;
			end
		end
		// A trigger during provision restarts it on the newer sample
		if (trig) begin
			st_nxt.snap = enc_count;
			st_nxt.phase = PH_PROV;
			st_nxt.pcnt = 12'h0;
		end else if (st_r.phase == PH_PROV) begin
			st_nxt.pcnt = st_r.pcnt + 12'h1;
			if (st_r.pcnt == PROV_LAST) begin
				st_nxt.phase = PH_IDLE;
				st_nxt.ready = 1'b1;
				st_nxt.ready_val = st_r.snap;
				if (st_r.meas_en) begin
					st_nxt.meas = 32'(({20'h0, st_r.pcnt} + 32'h1) * NS_STEP);
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
			st_r.cycle <= CYCLE_RST;
			st_r.mult <= MULT_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign apb_rsp = st_r.rsp;
	assign pd_value = st_r.pd;
	assign pd_fresh = st_r.fresh;
	assign sync0 = st_r.sync0;
	assign sync0_en = st_r.sync0_en;

	sync_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
		sync0 |-> sync0_en) else $error("sync0 outside clock mode");
	shift_frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
		$past(st_r.run) |-> $stable(st_r.shift) && $stable(st_r.mode))
		else $error("config changed while running");
	frame_sample_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.run && st_r.mode == MODE_FRAME && frame_done |=> st_r.snap == $past(enc_count))
		else $error("frame did not sample");
	prov_time_a: assert property (@(posedge pclk) disable iff (!presetn)
		trig ##1 (!trig && !frame_fetch) [*8] |-> !st_r.ready || $past(st_r.ready, 9))
		else $error("data ready too early");
	prov_done_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.phase == PH_PROV && st_r.pcnt == PROV_LAST && !trig |=> st_r.ready
		&& st_r.ready_val == $past(st_r.snap)) else $error("provision not finished");
	fetch_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		frame_fetch && st_r.run && st_r.ready |=> pd_value == $past(st_r.ready_val)
		&& pd_fresh) else $error("fetch did not deliver");
	late_miss_a: assert property (@(posedge pclk) disable iff (!presetn)
		frame_fetch && st_r.run && !st_r.ready |=> !pd_fresh && $stable(pd_value))
		else $error("late value offered");
	period_step_a: assert property (@(posedge pclk) disable iff (!presetn)
		dc_hit |=> st_r.next_evt == $past(st_r.next_evt) + $past(period))
		else $error("period step wrong");
	sync_align_a: assert property (@(posedge pclk) disable iff (!presetn)
		dc_hit |-> $signed(st_r.now - st_r.next_evt) < 32'sd100)
		else $error("sync late by 100 ns");
	no_frame_dc_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.mode != MODE_FRAME && !dc_hit |=> $stable(st_r.snap) || $past(trig))
		else $error("sample without sync0");
	apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
		else $error("no ready in access");

	ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		apb_rsp.pready
		|=> !apb_rsp.pready)
		else $error("ready held too long");

	err_with_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		apb_rsp.pslverr
		|-> apb_rsp.pready)
		else $error("error without ready");

	err_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup && apb_req.paddr > ADDR_STATUS
		|=> apb_rsp.pslverr)
		else $error("unmapped access not flagged");

	held_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup && !apb_req.pwrite && apb_req.paddr == ADDR_HELD
		|=> apb_rsp.prdata == $past(st_r.pd))
		else $error("held value read wrong");

	run_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.run
		|=> st_r.run)
		else $error("run dropped without reset");

	mode_legal_a: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1
		|-> st_r.mode inside {MODE_FRAME, MODE_DC, MODE_INPUT})
		else $error("illegal mode held");

	cfg_frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.run
		|=> $stable(st_r.cycle) && $stable(st_r.mult) && $stable(st_r.inshift))
		else $error("timing config changed while running");

	en_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.sync0_en
		|-> st_r.run && st_r.mode != MODE_FRAME)
		else $error("sync enabled in frame mode");

	en_on_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.run && st_r.mode != MODE_FRAME
		|-> st_r.sync0_en)
		else $error("sync not enabled in clock mode");

	frame_no_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.mode == MODE_FRAME
		|-> !sync0)
		else $error("sync pulse in frame mode");

	sync_trig_a: assert property (@(posedge pclk) disable iff (!presetn)
		dc_hit
		|=> sync0 && st_r.snap == $past(enc_count))
		else $error("sync event did not sample");

	hit_en_a: assert property (@(posedge pclk) disable iff (!presetn)
		dc_hit
		|-> st_r.sync0_en)
		else $error("sync event while disabled");

	idle_no_trig_a: assert property (@(posedge pclk) disable iff (!presetn)
		!st_r.run
		|=> $stable(st_r.snap))
		else $error("sample taken while stopped");

	snap_only_trig_a: assert property (@(posedge pclk) disable iff (!presetn)
		!trig
		|=> $stable(st_r.snap))
		else $error("sample without trigger");

	busy_after_trig_a: assert property (@(posedge pclk) disable iff (!presetn)
		trig
		|=> st_r.phase == PH_PROV && st_r.pcnt == 12'h0)
		else $error("provision not restarted");

	count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.phase == PH_PROV && !trig && st_r.pcnt != PROV_LAST
		|=> st_r.phase == PH_PROV && st_r.pcnt == $past(st_r.pcnt) + 12'h1)
		else $error("provision count skipped");

	count_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.phase == PH_PROV
		|-> st_r.pcnt <= PROV_LAST)
		else $error("provision count overrun");

	idle_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.phase == PH_IDLE && !trig
		|=> st_r.phase == PH_IDLE && $stable(st_r.ready_val))
		else $error("idle provision moved");

	meas_value_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.phase == PH_PROV && st_r.pcnt == PROV_LAST && !trig && st_r.meas_en
		|=> st_r.meas == 32'(PROV_CYC * CLK_NS))
		else $error("measured duration wrong");

	meas_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!st_r.meas_en
		|=> $stable(st_r.meas))
		else $error("measurement without request");

	fetch_only_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(frame_fetch && st_r.run)
		|=> $stable(pd_fresh) && $stable(pd_value))
		else $error("process data moved without fetch");

	ready_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		frame_fetch && st_r.run && st_r.ready && !(st_r.phase == PH_PROV && !trig)
		|=> !st_r.ready)
		else $error("ready kept after fetch");

	missed_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.missed
		|=> st_r.missed)
		else $error("missed flag cleared");

	next_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.run && !dc_hit
		|=> $stable(st_r.next_evt))
		else $error("event time moved between events");

	now_step_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.run
		|=> st_r.now == 32'($past(st_r.now) + NS_STEP))
		else $error("time base step wrong");

	inref_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.mode == MODE_DC && !st_r.inref
		|-> shift_tot == st_r.shift)
		else $error("input shift used without reference");

	input_add_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.mode == MODE_INPUT
		|-> shift_tot == 32'(st_r.shift + st_r.inshift))
		else $error("input shift missing");
endmodule
`default_nettype wire

// file: verification/cstt_frame_master.sv
// Fieldbus master model issuing periodic frames
`timescale 1ns/1ps
`default_nettype none
module cstt_frame_master #(
	parameter int FRAME_CYC = 4000
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic frames_on,
	// Frame events
	output logic frame_done,
	output logic frame_fetch
);
	int cnt_r;
	// Fetch comes first, exchange one cycle later, as one frame passing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 0;
			frame_fetch <= 1'b0;
			frame_done <= 1'b0;
		end else begin
			cnt_r <= (cnt_r == FRAME_CYC - 1 || !frames_on) ? 0 : cnt_r + 1;
			frame_fetch <= frames_on && cnt_r == FRAME_CYC - 2;
			frame_done <= frames_on && cnt_r == FRAME_CYC - 1;
		end
	end
endmodule
`default_nettype wire

// file: verification/test_counter_sample_trigger_timing.sv
// Self-checking bench for the sample trigger timing block
`timescale 1ns/1ps
`default_nettype none
module test_counter_sample_trigger_timing import cstt_pkg::*;;
	logic pclk = 1'b0;
	logic presetn, frames_on, frame_done, frame_fetch, pd_fresh, sync0, sync0_en, e;
	logic [31:0] enc_count, pd_value, v, exp_val, snap_q;
	cstt_apb_req_t req;
	cstt_apb_rsp_t rsp;
	int error_cnt = 0, total_checks = 0, age = 0, cyc = 0, last = -1, nsync = 0;
	bit run_frame = 0, dc_on = 0, have = 0, exp_fresh = 0, chk_due = 0;
	integer seed = 32'h77c27c55;
	always #12.5 pclk = ~pclk;
	cstt_trigger u_cstt_trigger (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.frame_done(frame_done), .frame_fetch(frame_fetch), .enc_count(enc_count),
		.pd_value(pd_value), .pd_fresh(pd_fresh), .sync0(sync0), .sync0_en(sync0_en));
	cstt_frame_master u_cstt_frame_master (.pclk(pclk), .presetn(presetn),
		.frames_on(frames_on), .frame_done(frame_done), .frame_fetch(frame_fetch));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge pclk);
		req.penable <= 1'b1;
		@(posedge pclk);
		while (rsp.pready !== 1'b1) begin
			@(posedge pclk);
		end
		v = rsp.prdata;
		e = rsp.pslverr;
		req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(v, exp);
	endtask
	task automatic conclude;
		$display("errors=%0d checks=%0d", error_cnt, total_checks);
		if (error_cnt == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Reference model of sampling and sync spacing
	always @(posedge pclk) begin
		enc_count <= $random(seed);
		cyc++;
		if (chk_due) begin
			chk(pd_value, exp_val);
			chk({31'h0, pd_fresh}, {31'h0, exp_fresh});
		end
		chk_due = 0;
		if (presetn && run_frame) begin
			age++;
			if (frame_fetch) begin
				exp_fresh = have && age >= 3201;
				if (exp_fresh)
					exp_val = snap_q;
				chk_due = 1;
			end
			if (frame_done) begin
				snap_q = enc_count;
				have = 1;
				age = 0;
			end
		end
		if (sync0 === 1'b1) begin
			chk({31'h0, dc_on}, 32'h1);
			if (last >= 0)
				chk(32'(cyc - last), 32'd4000);
			last = cyc;
			nsync++;
		end
	end
	initial begin
		repeat (60000) @(posedge pclk);
		error_cnt++;
		conclude;
	end
	initial begin
		presetn = 1'b0;
		req = '0;
		enc_count = 32'h0;
		frames_on = 1'b0;
		exp_val = 32'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(ADDR_CTRL, 32'h0);
		rd(ADDR_CYCLE, CYCLE_RST);
		rd(ADDR_MULT, MULT_RST);
		rd(8'h20, 32'h0);
		chk({31'h0, e}, 32'h1);
		apb(1'b1, ADDR_CTRL, 32'h0000_0024);
		run_frame = 1;
		frames_on <= 1'b1;
		apb(1'b1, ADDR_CYCLE, 32'h0000_1234);
		rd(ADDR_CYCLE, CYCLE_RST);
		repeat (8200) @(posedge pclk);
		rd(ADDR_MEAS, 32'h0001_3880);
		// First fetch missed, second fresh, second sample still in provision
		rd(ADDR_STATUS, 32'h0000_000D);
		chk(v & 32'h8, 32'h8);
		chk({31'h0, sync0_en}, 32'h0);
		// Second reset in mid-run, then clock-synchronous mode
		presetn <= 1'b0;
		run_frame = 0;
		frames_on <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, ADDR_CYCLE, 32'h0000_C350);
		apb(1'b1, ADDR_MULT, 32'h0000_0002);
		apb(1'b1, ADDR_SHIFT, 32'hFFFF_FC18);
		apb(1'b1, ADDR_CTRL, 32'h0000_0015);
		dc_on = 1;
		repeat (13000) @(posedge pclk);
		chk({31'h0, sync0_en}, 32'h1);
		chk(32'(nsync >= 3), 32'h1);
		// Third run: input-aligned mode, user period, input shift
		presetn <= 1'b0;
		dc_on = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		last = -1;
		nsync = 0;
		apb(1'b1, ADDR_CYCLE, 32'h0001_86A0);
		apb(1'b1, ADDR_MULT, 32'h0000_0000);
		apb(1'b1, ADDR_SHIFT, 32'h0000_03E8);
		apb(1'b1, ADDR_INSHIFT, 32'hFFFF_F830);
		apb(1'b1, ADDR_CTRL, 32'h0000_0006);
		dc_on = 1;
		rd(ADDR_CTRL, 32'h0000_0006);
		rd(ADDR_INSHIFT, 32'hFFFF_F830);
		repeat (13000) @(posedge pclk);
		chk({31'h0, sync0_en}, 32'h1);
		chk(32'(nsync >= 3), 32'h1);
		conclude;
	end
endmodule
`default_nettype wire
